// file: hdl/nvmsc_defines.vh
`ifndef NVMSC_DEFINES_VH
`define NVMSC_DEFINES_VH

// Register indices on the plain register port; byte address is four times the index.
`define NVMSC_ADDR_MBX_DAP 4'h0
`define NVMSC_ADDR_MBX_APP 4'h1
`define NVMSC_ADDR_MBX_EXE 4'h2
`define NVMSC_ADDR_LOCK 4'h3
`define NVMSC_ADDR_NOTIFY 4'h4
`define NVMSC_ADDR_RELMASK 4'h5
`define NVMSC_ADDR_CTRL 4'h6
`define NVMSC_ADDR_STATUS 4'h7
`define NVMSC_ADDR_PCTX 4'h8
`define NVMSC_ADDR_LASTOP 4'h9

// Requester numbers.
`define NVMSC_REQ_DAP 2'h0
`define NVMSC_REQ_APP 2'h1
`define NVMSC_REQ_EXE 2'h2

// Inline word fields.
`define NVMSC_OPC_HI 31
`define NVMSC_OPC_LO 24
`define NVMSC_INLINE_BIT 0
`define NVMSC_STAT_HI 31
`define NVMSC_STAT_LO 28

// Status codes.
`define NVMSC_STAT_OK 4'hA
`define NVMSC_STAT_ERR 4'hF

// Opcodes.
`define NVMSC_OP_SILID 8'h00
`define NVMSC_OP_BLOW 8'h01
`define NVMSC_OP_HASH 8'h02
`define NVMSC_OP_RDFUSE 8'h03
`define NVMSC_OP_WRROW 8'h05
`define NVMSC_OP_PGROW 8'h06
`define NVMSC_OP_ERALL 8'h0A
`define NVMSC_OP_CKSUM 8'h0B
`define NVMSC_OP_ERSECT 8'h14
`define NVMSC_OP_SRST 8'h1B
`define NVMSC_OP_ERROW 8'h1C

// Control bits and reset values.
`define NVMSC_CTRL_PROT_LO 0
`define NVMSC_CTRL_TBL_FLASH 4
`define NVMSC_CTRL_DBG_ACQ 5
`define NVMSC_PROT_UNKNOWN 4'h0
`define NVMSC_CTRL_RST 32'h00000000

// Flash geometry.
`define NVMSC_ROW_BYTES 512
`define NVMSC_RWW_SECTOR_BYTES 524288

// Protection context run by the executor.
`define NVMSC_PC_EXEC 4'h0

`endif

// file: hdl/nvmsc_decode.v
`timescale 1ns/1ps
`include "nvmsc_defines.vh"

module nvmsc_decode (
    input wire [7:0] opcode_in, // Opcode byte
    input wire tbl_flash_in, // Jump table held in flash
    output reg known_out, // Opcode is recognised
    output reg [4:0] entry_out, // Jump table slot
    output reg uses_sram_out, // Call takes SRAM parameters
    output reg flash_op_out, // Call writes flash
    output reg tbl_flash_out // Slot is taken from the flash table
);

always @* begin
    known_out = 1'b1;
    uses_sram_out = 1'b0;
    flash_op_out = 1'b0;
    entry_out = opcode_in[4:0];
    tbl_flash_out = tbl_flash_in;
    case (opcode_in)
        `NVMSC_OP_SILID, `NVMSC_OP_BLOW, `NVMSC_OP_RDFUSE: begin
        end
        `NVMSC_OP_HASH: begin
            uses_sram_out = 1'b1;
        end
        `NVMSC_OP_SRST: begin
        end
        `NVMSC_OP_WRROW, `NVMSC_OP_PGROW: begin
            uses_sram_out = 1'b1;
            flash_op_out = 1'b1;
        end
        `NVMSC_OP_ERROW: begin
            flash_op_out = 1'b1;
        end
        `NVMSC_OP_CKSUM: begin
            uses_sram_out = 1'b1;
        end
        `NVMSC_OP_ERSECT, `NVMSC_OP_ERALL: begin
            flash_op_out = 1'b1;
        end
        default: begin
            known_out = 1'b0;
            entry_out = 5'h1F;
        end
    endcase
end

endmodule // nvmsc_decode

// file: hdl/nvmsc_sync.v
`timescale 1ns/1ps

module nvmsc_sync #(
    parameter WIDTH = 3
) (
    input wire clock_in, // System clock
    input wire sys_rst_in, // Synchronous reset
    input wire [WIDTH-1:0] async_in, // Pins from outside
    output reg [WIDTH-1:0] sync_out // Synchronised levels
);

reg [WIDTH-1:0] stage1_reg;

always @(posedge clock_in) begin
    if (sys_rst_in) begin
        stage1_reg <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        stage1_reg <= async_in;
        sync_out <= stage1_reg;
    end
end

endmodule // nvmsc_sync

// file: hdl/nvmsc_mailbox.v
`timescale 1ns/1ps
`include "nvmsc_defines.vh"

// Notes on behaviour
// - One 32-bit word; short debug requests go inline with bit 0 set.
// - Bit 0 clear means word-aligned SRAM pointer; set means inline decode.
// - Protection state unknown: requests ignored, nothing performed.
// - Dispatch through a jump table in ROM or flash, per configuration.
// - SRAM results are written before the mailbox is released.
// - Scalar results go into the data field, then the lock is released.
// - After debug acquisition the executor keeps servicing debug requests.
// - Completion releases the calling mailbox; interrupt only if mask bit set.
// - On exit restore active protection context from the saved copy.
// - Opcodes 0x00, 0x01, 0x03: identity, blow fuse bit, read fuse byte.
// - Opcode 0x02 hash using SRAM; 0x1B soft reset of cores.
// - Opcodes 0x05 write row, 0x06 program row, 0x1C erase row.
// - Opcode 0x0B returns the byte sum of flash or one row.
// - Opcode 0x14 erases a sector, 0x0A all flash; no SRAM.
// - Every flash write is performed by the executor alone.
// - Rows are 512 bytes; read-while-write sectors are 512KB.
// - Calls run in protection context 0 inside the executor handler.
// - Inline debug results carry status 0xA or 0xF in bits 31..28.

module nvmsc_mailbox #(
    parameter ROW_BYTES = `NVMSC_ROW_BYTES,
    parameter SECTOR_BYTES = `NVMSC_RWW_SECTOR_BYTES
) (
    input wire clock_in, // 40 MHz system clock
    input wire sys_rst_in, // Synchronous reset, active high
    input wire [3:0] addr_in, // Register index
    input wire [31:0] wdata_in, // Register write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    output reg [31:0] rdata_out, // Read data, cycle after read strobe
    input wire [2:0] notify_pin_in, // Notify requests from outside
    output reg [31:0] sram_addr_out, // SRAM byte address, word aligned
    output reg sram_rd_out, // SRAM read pulse
    output reg sram_wr_out, // SRAM write pulse
    output reg [31:0] sram_wdata_out, // SRAM write data
    input wire [31:0] sram_rdata_in, // SRAM read data, next cycle
    output reg [5:0] op_start_out, // Start pulse to the selected routine
    output reg [4:0] op_entry_out, // Jump table slot
    output reg op_tbl_flash_out, // Slot taken from flash table
    output reg [31:0] op_arg_out, // Argument word
    input wire op_done_in, // Routine finished
    input wire [31:0] op_result_in, // Routine result
    input wire op_fail_in, // Routine failed
    output reg [3:0] active_pc_out, // Active protection context
    output reg [2:0] release_irq_out // Release interrupt per mailbox
);

//////////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 3'h0;
localparam S_FETCH = 3'h1;
localparam S_WAIT = 3'h2;
localparam S_RUN = 3'h3;
localparam S_WBACK = 3'h4;
localparam S_EXIT = 3'h5;
localparam S_REL = 3'h6;

localparam [31:0] ROW_BYTES_W = ROW_BYTES;
localparam [31:0] SECTOR_BYTES_W = SECTOR_BYTES;

reg [31:0] mbx_reg [0:2];
reg [2:0] lock_reg;
reg [2:0] relmask_reg;
reg [31:0] ctrl_reg;
reg [2:0] pend_reg;
reg [2:0] state_reg;
reg [1:0] cur_reg;
reg inline_reg;
reg [31:0] ptr_reg;
reg [31:0] cmd_reg;
reg [3:0] saved_pc_reg;
reg [7:0] lastop_reg;
reg [3:0] laststat_reg;
wire [2:0] notify_sync;
wire known;
wire [4:0] entry;
wire tbl_flash;
reg [1:0] pick;
reg pick_ok;
integer i;
integer j;

// Puts a status code into the top nibble of a result word.
function [31:0] with_status;
    input [31:0] word;
    input [3:0] stat;
    begin
        with_status = {stat, word[27:0]};
    end
endfunction

// Maps an opcode onto a routine class: 0 fuse, 1 hash, 2 reset,
// 3 flash write, 4 checksum, 5 identity.
function [2:0] op_class;
    input [7:0] op;
    begin
        case (op)
            `NVMSC_OP_BLOW, `NVMSC_OP_RDFUSE: op_class = 3'h0;
            `NVMSC_OP_HASH: op_class = 3'h1;
            `NVMSC_OP_SRST: op_class = 3'h2;
            `NVMSC_OP_CKSUM: op_class = 3'h4;
            `NVMSC_OP_SILID: op_class = 3'h5;
            default: op_class = 3'h3;
        endcase
    end
endfunction

//////////////////////////////////////////////////////////////////////////////
nvmsc_sync #(
    .WIDTH(3)
) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in(notify_pin_in),
    .sync_out(notify_sync)
);

// The decoder reads the latched command, so its outputs settle in S_RUN.
nvmsc_decode u_decode (
    .opcode_in(cmd_reg[`NVMSC_OPC_HI:`NVMSC_OPC_LO]),
    .tbl_flash_in(ctrl_reg[`NVMSC_CTRL_TBL_FLASH]),
    .known_out(known),
    .entry_out(entry),
    .uses_sram_out(),
    .flash_op_out(),
    .tbl_flash_out(tbl_flash)
);

// Debug port wins while it holds the device; otherwise lowest number first.
// Cores stay locked and pending for as long as the debug port holds the device.
always @* begin
    pick = `NVMSC_REQ_DAP;
    pick_ok = 1'b0;
    if (ctrl_reg[`NVMSC_CTRL_DBG_ACQ]) begin
        pick_ok = pend_reg[0] & lock_reg[0];
    end else if (pend_reg[0] & lock_reg[0]) begin
        pick_ok = 1'b1;
    end else if (pend_reg[1] & lock_reg[1]) begin
        pick = `NVMSC_REQ_APP;
        pick_ok = 1'b1;
    end else if (pend_reg[2] & lock_reg[2]) begin
        pick = `NVMSC_REQ_EXE;
        pick_ok = 1'b1;
    end
end

//////////////////////////////////////////////////////////////////////////////
// Notify edges and register writes, with hardware set beating clear.
// The edge detector resets low like an idle pin, so reset makes no false request.
reg [2:0] notify_d_reg;

always @(posedge clock_in) begin
    if (sys_rst_in) begin
        notify_d_reg <= 3'h0;
        pend_reg <= 3'h0;
        relmask_reg <= 3'h0;
        ctrl_reg <= `NVMSC_CTRL_RST;
    end else begin
        notify_d_reg <= notify_sync;
        if (wr_in && addr_in == `NVMSC_ADDR_RELMASK) begin
            relmask_reg <= wdata_in[2:0];
        end
        if (wr_in && addr_in == `NVMSC_ADDR_CTRL) begin
            ctrl_reg <= {26'h0000000, wdata_in[5:0]};
        end
        // A request waits in pend_reg until the executor is idle.
        for (i = 0; i < 3; i = i + 1) begin
            if (state_reg == S_IDLE && pick_ok && pick == i[1:0]) begin
                pend_reg[i] <= 1'b0;
            end
            if (wr_in && addr_in == `NVMSC_ADDR_NOTIFY && wdata_in[i]) begin
                pend_reg[i] <= 1'b1;
            end
            if (notify_sync[i] && !notify_d_reg[i]) begin
                pend_reg[i] <= 1'b1;
            end
        end
    end
end

//////////////////////////////////////////////////////////////////////////////
// Executor sequence.
always @(posedge clock_in) begin
    if (sys_rst_in) begin
        state_reg <= S_IDLE;
        cur_reg <= 2'h0;
        inline_reg <= 1'b0;
        ptr_reg <= 32'h00000000;
        cmd_reg <= 32'h00000000;
        saved_pc_reg <= `NVMSC_PC_EXEC;
        active_pc_out <= `NVMSC_PC_EXEC;
        lastop_reg <= 8'h00;
        laststat_reg <= 4'h0;
        lock_reg <= 3'h0;
        mbx_reg[0] <= 32'h00000000;
        mbx_reg[1] <= 32'h00000000;
        mbx_reg[2] <= 32'h00000000;
        sram_addr_out <= 32'h00000000;
        sram_rd_out <= 1'b0;
        sram_wr_out <= 1'b0;
        sram_wdata_out <= 32'h00000000;
        op_start_out <= 6'h00;
        op_entry_out <= 5'h00;
        op_tbl_flash_out <= 1'b0;
        op_arg_out <= 32'h00000000;
        release_irq_out <= 3'h0;
    end else begin
        sram_rd_out <= 1'b0;
        sram_wr_out <= 1'b0;
        op_start_out <= 6'h00;
        release_irq_out <= 3'h0;
        // Lock bits are set by software and cleared only on release.
        if (wr_in && addr_in == `NVMSC_ADDR_LOCK) begin
            for (j = 0; j < 3; j = j + 1) begin
                if (wdata_in[j]) begin
                    lock_reg[j] <= 1'b1;
                end
            end
        end
        if (wr_in && addr_in <= `NVMSC_ADDR_MBX_EXE) begin
            mbx_reg[addr_in[1:0]] <= wdata_in;
        end
        // Software sets the caller's context while idle; a call saves and restores it.
        if (wr_in && addr_in == `NVMSC_ADDR_PCTX && state_reg == S_IDLE) begin
            active_pc_out <= wdata_in[3:0];
        end
        case (state_reg)
            S_IDLE: begin
                if (pick_ok) begin
                    cur_reg <= pick;
                    if (ctrl_reg[3:0] == `NVMSC_PROT_UNKNOWN) begin
                        // The request is dropped but its lock stays held.
                        state_reg <= S_IDLE;
                    end else begin
                        saved_pc_reg <= active_pc_out;
                        active_pc_out <= `NVMSC_PC_EXEC;
                        inline_reg <= mbx_reg[pick][`NVMSC_INLINE_BIT];
                        ptr_reg <= {mbx_reg[pick][31:2], 2'b00};
                        if (mbx_reg[pick][`NVMSC_INLINE_BIT]) begin
                            cmd_reg <= mbx_reg[pick];
                            state_reg <= S_RUN;
                        end else begin
                            sram_addr_out <= {mbx_reg[pick][31:2], 2'b00};
                            sram_rd_out <= 1'b1;
                            state_reg <= S_FETCH;
                        end
                    end
                end
            end
            S_FETCH: begin
                // The SRAM answers one cycle after it sees the read pulse.
                state_reg <= S_WAIT;
            end
            S_WAIT: begin
                cmd_reg <= sram_rdata_in;
                state_reg <= S_RUN;
            end
            S_RUN: begin
                lastop_reg <= cmd_reg[`NVMSC_OPC_HI:`NVMSC_OPC_LO];
                if (!known) begin
                    laststat_reg <= `NVMSC_STAT_ERR;
                    // A refused opcode hands back an all-zero result field.
                    cmd_reg <= 32'h00000000;
                    state_reg <= S_WBACK;
                end else begin
                    // Flash writes start only here, from the executor.
                    op_start_out[op_class(cmd_reg[`NVMSC_OPC_HI:`NVMSC_OPC_LO])] <= 1'b1;
                    op_entry_out <= entry;
                    op_tbl_flash_out <= tbl_flash;
                    op_arg_out <= cmd_reg;
                    state_reg <= S_EXIT;
                end
            end
            S_EXIT: begin
                // The result replaces the command word; the opcode is in lastop_reg.
                if (op_done_in) begin
                    laststat_reg <= op_fail_in ? `NVMSC_STAT_ERR : `NVMSC_STAT_OK;
                    cmd_reg <= op_result_in;
                    state_reg <= S_WBACK;
                end
            end
            S_WBACK: begin
                // The result lands a cycle before the release, so a free lock means ready.
                if (inline_reg) begin
                    mbx_reg[cur_reg] <= with_status(cmd_reg,
                        laststat_reg);
                end else begin
                    sram_addr_out <= ptr_reg;
                    sram_wdata_out <= with_status(cmd_reg,
                        laststat_reg);
                    sram_wr_out <= 1'b1;
                end
                state_reg <= S_REL;
            end
            S_REL: begin
                lock_reg[cur_reg] <= 1'b0;
                release_irq_out[cur_reg] <= relmask_reg[cur_reg];
                active_pc_out <= saved_pc_reg;
                state_reg <= S_IDLE;
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

//////////////////////////////////////////////////////////////////////////////
// Read port; row and sector sizes are exposed for software.
// Read data stand only in the cycle after the strobe and are zero otherwise.
always @(posedge clock_in) begin
    if (sys_rst_in) begin
        rdata_out <= 32'h00000000;
    end else if (rd_in) begin
        case (addr_in)
            `NVMSC_ADDR_MBX_DAP: rdata_out <= mbx_reg[0];
            `NVMSC_ADDR_MBX_APP: rdata_out <= mbx_reg[1];
            `NVMSC_ADDR_MBX_EXE: rdata_out <= mbx_reg[2];
            `NVMSC_ADDR_LOCK: rdata_out <= {29'h0, lock_reg};
            `NVMSC_ADDR_NOTIFY: rdata_out <= {29'h0, pend_reg};
            `NVMSC_ADDR_RELMASK: rdata_out <= {29'h0, relmask_reg};
            `NVMSC_ADDR_CTRL: rdata_out <= ctrl_reg;
            `NVMSC_ADDR_STATUS: rdata_out <= {ROW_BYTES_W[15:0], 9'h000, state_reg,
                laststat_reg};
            `NVMSC_ADDR_PCTX: rdata_out <= {24'h000000, saved_pc_reg, active_pc_out};
            `NVMSC_ADDR_LASTOP: rdata_out <= {SECTOR_BYTES_W[23:0], lastop_reg};
            default: rdata_out <= 32'h00000000;
        endcase
    end else begin
        rdata_out <= 32'h00000000;
    end
end

endmodule // nvmsc_mailbox

// file: tb/nvmsc_chk.sv
`timescale 1ns/1ps
`include "nvmsc_defines.vh"

module nvmsc_chk (
    input wire clock_in, // System clock
    input wire sys_rst_in, // Synchronous reset
    input wire [3:0] addr_in, // Register index
    input wire [31:0] wdata_in, // Register write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire [31:0] rdata_out, // Read data
    input wire sram_rd_out, // SRAM read pulse
    input wire sram_wr_out, // SRAM write pulse
    input wire [5:0] op_start_out, // Routine start
    input wire [4:0] op_entry_out, // Jump table slot
    input wire [31:0] op_arg_out, // Argument word
    input wire [3:0] active_pc_out, // Active context
    input wire [2:0] release_irq_out // Release interrupts
);
    reg [2:0] mask_reg;
    reg [3:0] prot_reg;

    // Shadows of the release mask and protection state, taken from register writes.
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            mask_reg <= 3'h0;
            prot_reg <= 4'h0;
        end else if (wr_in && addr_in == `NVMSC_ADDR_RELMASK) begin
            mask_reg <= wdata_in[2:0];
        end else if (wr_in && addr_in == `NVMSC_ADDR_CTRL) begin
            prot_reg <= wdata_in[3:0];
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 32'h00000000)
        else $error("read data outside its cycle");
    a_start_onehot: assert property (op_start_out != 6'h00 |-> $onehot(op_start_out))
        else $error("start not one-hot");
    a_start_single: assert property (op_start_out != 6'h00 |=> op_start_out == 6'h00)
        else $error("start longer than one cycle");
    a_arg_hold: assert property (op_start_out == 6'h00 |-> $stable(op_arg_out) && $stable(op_entry_out))
        else $error("routine argument moved without start");
    a_sram_excl: assert property (!(sram_rd_out && sram_wr_out))
        else $error("SRAM read and write together");
    a_sram_rd_pulse: assert property (sram_rd_out |=> !sram_rd_out)
        else $error("SRAM read longer than one cycle");
    a_rel_masked: assert property ((release_irq_out & ~mask_reg) == 3'h0)
        else $error("release interrupt on masked mailbox");
    a_rel_pulse: assert property (release_irq_out != 3'h0 |=> release_irq_out == 3'h0)
        else $error("release interrupt longer than one cycle");
    a_prot_idle: assert property (prot_reg == 4'h0 |-> op_start_out == 6'h00 && !sram_rd_out)
        else $error("call serviced while protection unknown");
    a_pc_exec: assert property (op_start_out != 6'h00 |-> active_pc_out == `NVMSC_PC_EXEC)
        else $error("routine started outside context zero");
endmodule // nvmsc_chk

// file: tb/nvmsc_far.sv
`timescale 1ns/1ps

module nvmsc_far (
    input wire clock_in, // System clock
    input wire [5:0] op_start_in, // Routine start
    output reg op_done_out, // Routine done
    output reg [31:0] op_result_out, // Routine result
    output reg op_fail_out, // Routine failed
    input wire [31:0] sram_addr_in, // SRAM address
    input wire sram_rd_in, // SRAM read
    input wire sram_wr_in, // SRAM write
    input wire [31:0] sram_wdata_in, // SRAM write data
    output reg [31:0] sram_rdata_out, // SRAM read data
    input wire [31:0] result_in, // Result to hand back
    input wire fail_in, // Report a failure
    input wire [7:0] delay_in // Cycles before done
);
    reg [31:0] mem [0:1023];
    integer busy_cnt;
    integer hold_cnt;

    initial begin
        op_done_out = 1'b0;
        op_result_out = 32'h00000000;
        op_fail_out = 1'b0;
        sram_rdata_out = 32'h00000000;
        busy_cnt = -1;
        hold_cnt = 0;
    end

    // Read data hold three cycles, then toggle so a late sample never looks valid.
    always @(posedge clock_in) begin
        if (sram_wr_in) begin
            mem[sram_addr_in[11:2]] <= sram_wdata_in;
        end
        if (sram_rd_in) begin
            sram_rdata_out <= mem[sram_addr_in[11:2]];
            hold_cnt <= 2;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            sram_rdata_out <= ~sram_rdata_out;
        end
        op_done_out <= 1'b0;
        if (op_start_in != 6'h00) begin
            busy_cnt <= delay_in;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end else if (busy_cnt == 0) begin
            op_done_out <= 1'b1;
            op_result_out <= result_in;
            op_fail_out <= fail_in;
            busy_cnt <= -1;
        end else begin
            op_result_out <= ~op_result_out;
            op_fail_out <= ~op_fail_out;
        end
    end
endmodule // nvmsc_far

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "nvmsc_defines.vh"

`define CHK(g, e) begin \
    check_count = check_count + 1; \
    if ((g) !== (e)) begin \
        n_errors = n_errors + 1; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
    end \
end

module testbench;
    reg clock_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [3:0] addr_in = 4'h0;
    reg [31:0] wdata_in = 32'h00000000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg [2:0] notify_pin_in = 3'h0;
    reg [31:0] result_val = 32'h00000000;
    reg fail_val = 1'b0;
    reg [7:0] delay_val = 8'h00;
    reg [2:0] mask_val = 3'h0;
    reg [5:0] starts = 6'h00;
    reg [2:0] rels = 3'h0;
    wire [31:0] rdata_out, sram_addr_out, sram_wdata_out, sram_rdata_in, op_arg_out, op_result_in;
    wire sram_rd_out, sram_wr_out, op_tbl_flash_out, op_done_in, op_fail_in;
    wire [5:0] op_start_out;
    wire [4:0] op_entry_out;
    wire [3:0] active_pc_out;
    wire [2:0] release_irq_out;
    integer n_errors = 0;
    integer check_count = 0;
    integer cycles = 0;
    localparam [87:0] OPS = {8'h1C, 8'h14, 8'h0B, 8'h0A, 8'h06, 8'h05, 8'h1B, 8'h02, 8'h03,
        8'h01, 8'h00};
    localparam [65:0] CLS = {6'h08, 6'h08, 6'h10, 6'h08, 6'h08, 6'h08, 6'h04, 6'h02, 6'h01,
        6'h01, 6'h20};

    nvmsc_mailbox dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .notify_pin_in(notify_pin_in), .sram_addr_out(sram_addr_out), .sram_rd_out(sram_rd_out),
        .sram_wr_out(sram_wr_out), .sram_wdata_out(sram_wdata_out), .sram_rdata_in(sram_rdata_in),
        .op_start_out(op_start_out), .op_entry_out(op_entry_out),
        .op_tbl_flash_out(op_tbl_flash_out), .op_arg_out(op_arg_out), .op_done_in(op_done_in),
        .op_result_in(op_result_in), .op_fail_in(op_fail_in), .active_pc_out(active_pc_out),
        .release_irq_out(release_irq_out));

    nvmsc_far far (.clock_in(clock_in), .op_start_in(op_start_out), .op_done_out(op_done_in),
        .op_result_out(op_result_in), .op_fail_out(op_fail_in), .sram_addr_in(sram_addr_out),
        .sram_rd_in(sram_rd_out), .sram_wr_in(sram_wr_out), .sram_wdata_in(sram_wdata_out),
        .sram_rdata_out(sram_rdata_in), .result_in(result_val), .fail_in(fail_val),
        .delay_in(delay_val));

    initial begin
        forever #12.5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        starts <= starts | op_start_out;
        rels <= rels | release_irq_out;
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    task wr(input [3:0] a, input [31:0] v);
        begin
            @(posedge clock_in);
            addr_in <= a;
            wdata_in <= v;
            wr_in <= 1'b1;
            @(posedge clock_in);
            wr_in <= 1'b0;
        end
    endtask

    task rd(input [3:0] a, output [31:0] v);
        begin
            @(posedge clock_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge clock_in);
            rd_in <= 1'b0;
            #1;
            v = rdata_out;
        end
    endtask

    // One call: lock, data, notify, then poll the lock and judge what came back.
    task call(input [1:0] m, input [31:0] w, input [5:0] c, input [31:0] e, input pin,
        input srv);
        integer i;
        reg [31:0] v;
        begin
            wr(`NVMSC_ADDR_LOCK, 32'h1 << m);
            wr({2'b00, m}, w);
            #1;
            starts = 6'h00;
            rels = 3'h0;
            if (pin) begin
                @(posedge clock_in);
                notify_pin_in[m] <= 1'b1;
                repeat (4) @(posedge clock_in);
                notify_pin_in[m] <= 1'b0;
            end else begin
                wr(`NVMSC_ADDR_NOTIFY, 32'h1 << m);
            end
            v = 32'hFFFFFFFF;
            for (i = 0; i < 60 && v[m] === 1'b1; i = i + 1) begin
                rd(`NVMSC_ADDR_LOCK, v);
            end
            `CHK(v[m], ~srv)
            rd({2'b00, m}, v);
            `CHK(v, e)
            `CHK(starts, c)
            `CHK(rels, srv ? (mask_val & (3'h1 << m)) : 3'h0)
            if (srv) begin
                rd(`NVMSC_ADDR_PCTX, v);
                `CHK(v[7:0], 8'h55)
            end
        end
    endtask

    task s_prot_unknown;
        reg [31:0] v;
        begin
            rd(`NVMSC_ADDR_CTRL, v);
            `CHK(v, `NVMSC_CTRL_RST)
            mask_val = 3'h7;
            wr(`NVMSC_ADDR_RELMASK, 32'h00000007);
            call(2'd0, 32'h00000001, 6'h00, 32'h00000001, 1'b0, 1'b0);
            wr(`NVMSC_ADDR_CTRL, 32'h00000003);
        end
    endtask

    task s_opcodes;
        integer i;
        begin
            wr(`NVMSC_ADDR_PCTX, 32'h00000005);
            for (i = 0; i < 11; i = i + 1) begin
                result_val = 32'h5ABC0000 + i;
                delay_val = i * 3;
                call(2'd0, {OPS[i*8+:8], 23'h0, 1'b1}, CLS[i*6+:6],
                    {`NVMSC_STAT_OK, result_val[27:0]}, i == 3, 1'b1);
                `CHK({op_entry_out, op_arg_out}, {OPS[i*8+:5], OPS[i*8+:8], 24'h000001})
            end
        end
    endtask

    task s_errors;
        reg [31:0] v;
        begin
            mask_val = 3'h6;
            wr(`NVMSC_ADDR_RELMASK, 32'h00000006);
            call(2'd0, 32'h7F000001, 6'h00, {`NVMSC_STAT_ERR, 28'h0}, 1'b0, 1'b1);
            rd(`NVMSC_ADDR_STATUS, v);
            `CHK(v, (`NVMSC_ROW_BYTES << 16) | `NVMSC_STAT_ERR)
            rd(`NVMSC_ADDR_LASTOP, v);
            `CHK(v, (`NVMSC_RWW_SECTOR_BYTES << 8) | 8'h7F)
            fail_val = 1'b1;
            result_val = 32'h01234567;
            call(2'd0, 32'h01000001, 6'h01, 32'hF1234567, 1'b0, 1'b1);
            fail_val = 1'b0;
        end
    endtask

    task s_pointer;
        begin
            far.mem[10'h040] = 32'h0B000000;
            result_val = 32'h0000BEEF;
            call(2'd1, 32'h00000100, 6'h10, 32'h00000100, 1'b0, 1'b1);
            `CHK(far.mem[10'h040], 32'hA000BEEF)
            `CHK(op_tbl_flash_out, 1'b0)
        end
    endtask

    task s_debug;
        begin
            far.mem[10'h080] = 32'h00000000;
            wr(`NVMSC_ADDR_CTRL, 32'h00000033);
            call(2'd1, 32'h00000200, 6'h00, 32'h00000200, 1'b0, 1'b0);
            result_val = 32'h00000042;
            call(2'd0, 32'h00000001, 6'h20, 32'hA0000042, 1'b0, 1'b1);
            `CHK({op_tbl_flash_out, op_entry_out}, 6'h20)
        end
    endtask

    initial begin
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        s_prot_unknown;
        s_opcodes;
        s_errors;
        s_pointer;
        s_debug;
        tally_and_finish;
    end
endmodule // testbench

bind nvmsc_mailbox nvmsc_chk chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sram_rd_out(sram_rd_out), .sram_wr_out(sram_wr_out),
    .op_start_out(op_start_out), .op_entry_out(op_entry_out), .op_arg_out(op_arg_out),
    .active_pc_out(active_pc_out), .release_irq_out(release_irq_out));
